// ### dv/odm_ctrl_checker.sv
// Port checker for the display memory access control block.
`timescale 1ns/100ps
module odm_ctrl_checker (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic data_wr_i,
    input wire logic [7:0] display_data_in_i,
    input wire logic external_sync_i,
    input wire logic background_mode_i,
    input wire logic char_local_background_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic mem_glyph_we_o,
    input wire logic mem_attr_we_o,
    input wire logic [8:0] mem_addr_o,
    input wire logic [7:0] mem_glyph_o,
    input wire logic [7:0] mem_attr_o,
    input wire logic clear_busy_o,
    input wire logic show_video_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);
    wire logic we = mem_glyph_we_o | mem_attr_we_o;
    wire logic start = clear_busy_o & mem_glyph_we_o & (mem_addr_o == 9'h000);
    property p_rd_high; reg_rd_i && reg_addr_i == 8'h85 |=>
        reg_rdata_o[7:2] == 6'h00; endproperty
    a_rd_high: assert property (p_rd_high)
        else $error("address high upper bits not zero");
    property p_clr_zero; clear_busy_o && we |-> mem_glyph_we_o &&
        mem_attr_we_o && mem_glyph_o == 8'h00 && mem_attr_o == 8'h00;
    endproperty
    a_clr_zero: assert property (p_clr_zero)
        else $error("clear wrote nonzero");
    property p_sweep; start |-> ##[511:511] (mem_addr_o == 9'h1FF && we);
    endproperty
    a_sweep: assert property (p_sweep)
        else $error("clear sweep incomplete");
    property p_busy_end; start |-> ##[1:600] !clear_busy_o; endproperty
    a_busy_end: assert property (p_busy_end)
        else $error("clear bit stuck");
    property p_rst_clear; $rose(reset_n_i) |-> ##[1:3] start; endproperty
    a_rst_clear: assert property (p_rst_clear)
        else $error("no clear after reset");
    property p_show; $past(reset_n_i) |-> show_video_o == $past(
        external_sync_i && !background_mode_i && !char_local_background_i);
    endproperty
    a_show: assert property (p_show)
        else $error("background select wrong");
    property p_data_wr; data_wr_i && !clear_busy_o &&
        display_data_in_i != 8'hFF |=> we; endproperty
    a_data_wr: assert property (p_data_wr)
        else $error("data byte not stored");
    property p_glyph; mem_glyph_we_o && !clear_busy_o &&
        !$past(clear_busy_o) |-> mem_glyph_o == $past(display_data_in_i);
    endproperty
    a_glyph: assert property (p_glyph)
        else $error("glyph byte wrong");
endmodule // odm_ctrl_checker

bind odm_ctrl odm_ctrl_checker i_odm_ctrl_checker (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i), .data_wr_i(data_wr_i),
    .display_data_in_i(display_data_in_i),
    .external_sync_i(external_sync_i),
    .background_mode_i(background_mode_i),
    .char_local_background_i(char_local_background_i),
    .reg_rdata_o(reg_rdata_o), .mem_glyph_we_o(mem_glyph_we_o),
    .mem_attr_we_o(mem_attr_we_o), .mem_addr_o(mem_addr_o),
    .mem_glyph_o(mem_glyph_o), .mem_attr_o(mem_attr_o),
    .clear_busy_o(clear_busy_o), .show_video_o(show_video_o));

// ### dv/odm_host.sv
// Serial host model issuing register, data and chip-select requests.
`timescale 1ns/100ps
module odm_host (
    input wire logic clock_i,
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic [7:0] reg_addr_o,
    output logic [7:0] reg_wdata_o,
    output logic data_wr_o,
    output logic [7:0] data_o,
    output logic cs_rise_o,
    output logic vm0_clear_o
);
    initial begin
        {reg_wr_o, reg_rd_o, data_wr_o, cs_rise_o, vm0_clear_o} = 5'h00;
        {reg_addr_o, reg_wdata_o, data_o} = 24'h000000;
    end
    // Released address and data lines show the inverse so stale values are never reused; strobes return to 0.
    // register access strobe
    task automatic reg_op(input logic rd, input logic [7:0] a, d);
        @(negedge clock_i);
        {reg_rd_o, reg_wr_o} = {rd, !rd};
        {reg_addr_o, reg_wdata_o} = {a, d};
        @(negedge clock_i);
        {reg_rd_o, reg_wr_o} = 2'b00;
        {reg_addr_o, reg_wdata_o} = ~{a, d};
    endtask
    task automatic data_op(input logic [7:0] d);
        @(negedge clock_i);
        {data_wr_o, data_o} = {1'b1, d};
        @(negedge clock_i);
        {data_wr_o, data_o} = {1'b0, ~d};
    endtask
    task automatic cs_end();
        @(negedge clock_i);
        {cs_rise_o, vm0_clear_o} = 2'b11;
        @(negedge clock_i);
        {cs_rise_o, vm0_clear_o} = 2'b00;
    endtask
endmodule // odm_host

// ### dv/tb.sv
// Self-checking bench for the display memory access control block.
`timescale 1ns/100ps
module tb;
    logic clock_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic vsync_i = 1'b0;
    logic external_sync_i = 1'b0;
    logic background_mode_i = 1'b0;
    logic char_local_background_i = 1'b0;
    logic [7:0] display_address_low_i = 8'h00;
    logic reg_wr_i, reg_rd_i, data_wr_i, cs_rise_i, video_mode_zero_clear_i;
    logic [7:0] reg_addr_i, reg_wdata_i, display_data_in_i, reg_rdata_o;
    logic mem_glyph_we_o, mem_attr_we_o, clear_busy_o, show_video_o;
    logic [8:0] mem_addr_o;
    logic [7:0] mem_glyph_o, mem_attr_o, low, d;
    logic rd_d = 1'b0;
    logic busy_d = 1'b1;
    logic h;
    logic [34:0] exq[$];
    int err_count = 0;
    int n_compared = 0;
    int cycles = 0;
    always #25 clock_i = ~clock_i;
    odm_host i_odm_host (.clock_i(clock_i), .reg_wr_o(reg_wr_i),
        .reg_rd_o(reg_rd_i), .reg_addr_o(reg_addr_i),
        .reg_wdata_o(reg_wdata_i), .data_wr_o(data_wr_i),
        .data_o(display_data_in_i), .cs_rise_o(cs_rise_i),
        .vm0_clear_o(video_mode_zero_clear_i));
    odm_ctrl i_odm_ctrl (.clock_i(clock_i), .reset_n_i(reset_n_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .cs_rise_i(cs_rise_i),
        .video_mode_zero_clear_i(video_mode_zero_clear_i),
        .display_address_low_i(display_address_low_i),
        .data_wr_i(data_wr_i), .display_data_in_i(display_data_in_i),
        .vsync_i(vsync_i), .external_sync_i(external_sync_i),
        .background_mode_i(background_mode_i),
        .char_local_background_i(char_local_background_i),
        .reg_rdata_o(reg_rdata_o), .mem_glyph_we_o(mem_glyph_we_o),
        .mem_attr_we_o(mem_attr_we_o), .mem_addr_o(mem_addr_o),
        .mem_glyph_o(mem_glyph_o), .mem_attr_o(mem_attr_o),
        .clear_busy_o(clear_busy_o), .show_video_o(show_video_o));
    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [34:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        check(exq.size(), 0);
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, v);
        i_odm_host.reg_op(1'b0, a, v);
    endtask
    task automatic rd(input logic [7:0] a, v);
        exq.push_back({27'h0, v});
        i_odm_host.reg_op(1'b1, a, 8'h00);
    endtask
    task automatic dw(input logic [7:0] v, input logic [34:0] e);
        if (e !== 35'h0) exq.push_back(e);
        i_odm_host.data_op(v);
    endtask
    task automatic idle(input string name);
        int n;
        n = 0;
        while (clear_busy_o !== 1'b0 && n < 1000) begin
            @(negedge clock_i);
            n++;
        end
        check(n < 1000, 1'b1);
        $display("test %0s done", name);
    endtask
    task automatic take(input logic [34:0] got);
        check(got, exq.size() ? exq.pop_front() : '1);
    endtask
    // ------------------------------------------------------------------
    // Result monitor and timeout
    // ------------------------------------------------------------------
    always @(posedge clock_i) begin
        rd_d <= reg_rd_i;
        // The last zero write of a clear leaves as busy drops; skip it too.
        busy_d <= clear_busy_o;
        cycles <= cycles + 1;
        if (cycles == 10000) begin
            err_count++;
            conclude();
        end
    end
    always @(negedge clock_i) begin
        if (rd_d) take({27'h0, reg_rdata_o});
        if ((mem_glyph_we_o | mem_attr_we_o) && !clear_busy_o && !busy_d)
            take({mem_glyph_we_o, mem_attr_we_o, mem_addr_o,
                mem_glyph_we_o ? mem_glyph_o : 8'h00,
                mem_attr_we_o ? mem_attr_o : 8'h00});
    end
    initial begin
        void'($urandom(80));
        repeat (16) @(negedge clock_i);
        reset_n_i = 1'b1;
        @(negedge clock_i);
        check(clear_busy_o, 1'b1);
        idle("reset");
        rd(8'h84, 8'h00);
        h = 1'($urandom);
        low = 8'($urandom);
        display_address_low_i = low;
        d = 8'($urandom_range(254));
        wr(8'h05, {7'h00, h});
        rd(8'h85, {7'h00, h});
        wr(8'h04, 8'h38);
        dw(d, {2'b11, h, low, d, 8'hE0});
        dw(8'hFF, {2'b11, h, low, 8'hFF, 8'hE0});
        wr(8'h04, 8'h40);
        wr(8'h05, {6'h00, 1'b1, h});
        dw(d, {2'b01, h, low, 8'h00, d});
        wr(8'h05, {7'h00, h});
        wr(8'h04, 8'h41);
        dw(d, {2'b10, h, low, d, 8'h00});
        dw(d >> 1, {2'b10, {h, low} + 9'h001, d >> 1, 8'h00});
        dw(8'hFF, 35'h0);
        rd(8'h84, 8'h40);
        wr(8'h04, 8'h05);
        rd(8'h84, 8'h04);
        wr(8'h05, 8'h03);
        idle("mode clear");
        rd(8'h85, {7'h00, h});
        wr(8'h04, 8'h06);
        repeat (40) @(negedge clock_i);
        check(mem_glyph_we_o, 1'b0);
        check(clear_busy_o, 1'b1);
        rd(8'h84, 8'h06);
        vsync_i = 1'b1;
        idle("deferred clear");
        vsync_i = 1'b0;
        rd(8'h84, 8'h02);
        dw(d, {2'b11, h, low, d, 8'h00});
        wr(8'h04, 8'h00);
        i_odm_host.cs_end();
        check(clear_busy_o, 1'b1);
        idle("chip select clear");
        for (int i = 0; i < 8; i++) begin
            {external_sync_i, background_mode_i,
                char_local_background_i} = 3'(i);
            @(negedge clock_i);
            check(show_video_o, i == 4);
        end
        $display("test background done");
        reset_n_i = 1'b0;
        repeat (4) @(negedge clock_i);
        reset_n_i = 1'b1;
        @(negedge clock_i);
        check(clear_busy_o, 1'b1);
        idle("second reset");
        rd(8'h84, 8'h00);
        @(negedge clock_i);
        conclude();
    end
endmodule // tb

// ### hdl/odm_ctrl.sv
// Display memory access control: clear, auto-increment and byte select.
`timescale 1ns/100ps

module odm_ctrl (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic cs_rise_i,
    input wire logic video_mode_zero_clear_i,
    input wire logic [7:0] display_address_low_i,
    input wire logic data_wr_i,
    input wire logic [7:0] display_data_in_i,
    input wire logic vsync_i,
    input wire logic external_sync_i,
    input wire logic background_mode_i,
    input wire logic char_local_background_i,
    output logic [7:0] reg_rdata_o,
    output logic mem_glyph_we_o,
    output logic mem_attr_we_o,
    output logic [8:0] mem_addr_o,
    output logic [7:0] mem_glyph_o,
    output logic [7:0] mem_attr_o,
    output logic clear_busy_o,
    output logic show_video_o
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    odm_pkg::odm_state_t state_r;
    odm_pkg::odm_state_t state_nxt;
    logic [7:0] mode_r;
    logic [7:0] mode_nxt;
    logic [1:0] high_r;
    logic [1:0] high_nxt;
    logic [8:0] ptr_r;
    logic [8:0] ptr_nxt;
    logic [9:0] clr_cnt_r;
    logic [9:0] clr_cnt_nxt;
    logic vsync_d_r;
    logic [7:0] reg_rdata_r;
    logic glyph_we_r;
    logic attr_we_r;
    logic [8:0] addr_r;
    logic [7:0] glyph_r;
    logic [7:0] attr_r;
    logic show_video_r;
    logic busy_r;

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    wire mode_wr = reg_wr_i && (reg_addr_i == odm_pkg::ADDR_MODE_WR);
    wire high_wr = reg_wr_i && (reg_addr_i == odm_pkg::ADDR_HIGH_WR);
    wire mode_rd = reg_rd_i && (reg_addr_i == odm_pkg::ADDR_MODE_RD);
    wire high_rd = reg_rd_i && (reg_addr_i == odm_pkg::ADDR_HIGH_RD);
    wire clearing = (state_r != odm_pkg::ST_IDLE);
    wire host_clear = mode_wr && reg_wdata_i[odm_pkg::MODE_CLEAR];
    wire vm0_clear = cs_rise_i && video_mode_zero_clear_i;
    wire clear_req = (host_clear || vm0_clear) && !clearing;
    wire vs_defer = mode_wr ? reg_wdata_i[odm_pkg::MODE_VS_CLEAR]
                            : mode_r[odm_pkg::MODE_VS_CLEAR];
    wire vsync_rise = vsync_i && !vsync_d_r;
    wire eight_bit = mode_r[odm_pkg::MODE_EIGHT_BIT];
    wire auto_on = mode_r[odm_pkg::MODE_AUTO_INC];
    wire auto_enable = mode_wr && reg_wdata_i[odm_pkg::MODE_AUTO_INC]
                       && !auto_on && !reg_wdata_i[odm_pkg::MODE_CLEAR];
    wire [8:0] host_addr = {high_r[odm_pkg::HIGH_MSB], display_address_low_i};
    wire data_ok = data_wr_i && !clearing;
    wire escape = data_ok && auto_on
                  && (display_data_in_i == odm_pkg::ESCAPE_CODE);
    wire store = data_ok && !escape;
    wire to_attr = eight_bit && high_r[odm_pkg::HIGH_BYTE_SEL];
    // The clear lasts the longer of the sweep and the minimum clear time.
    wire clr_last = (clr_cnt_r >= 10'(odm_pkg::MEM_DEPTH - 1))
                    && (clr_cnt_r >= 10'(odm_pkg::CLEAR_CYCLES - 1));
    wire [7:0] auto_attr = {mode_r[odm_pkg::MODE_LBC],
                            mode_r[odm_pkg::MODE_BLINK],
                            mode_r[odm_pkg::MODE_INV], 5'h00};

    // ------------------------------------------------------------------
    // Clear sequencer
    // ------------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        clr_cnt_nxt = clr_cnt_r;
        case (state_r)
            odm_pkg::ST_IDLE: begin
                clr_cnt_nxt = 10'h000;
                if (clear_req) begin
                    state_nxt = vs_defer ? odm_pkg::ST_WAIT_VS
                                         : odm_pkg::ST_CLEAR;
                end
            end
            odm_pkg::ST_WAIT_VS: begin
                if (vsync_rise) begin
                    state_nxt = odm_pkg::ST_CLEAR;
                end
            end
            odm_pkg::ST_CLEAR: begin
                if (clr_last) begin
                    state_nxt = odm_pkg::ST_IDLE;
                end else begin
                    clr_cnt_nxt = clr_cnt_r + 10'h001;
                end
            end
            default: begin
                state_nxt = odm_pkg::ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Register next values
    // ------------------------------------------------------------------
    always_comb begin
        mode_nxt = mode_r;
        if (mode_wr) begin
            mode_nxt[7:3] = reg_wdata_i[7:3];
            mode_nxt[odm_pkg::MODE_VS_CLEAR] =
                reg_wdata_i[odm_pkg::MODE_VS_CLEAR];
            mode_nxt[odm_pkg::MODE_AUTO_INC] =
                reg_wdata_i[odm_pkg::MODE_AUTO_INC];
        end
        mode_nxt[7] = 1'b0;
        if (escape) begin
            mode_nxt[odm_pkg::MODE_AUTO_INC] = 1'b0;
        end
        mode_nxt[odm_pkg::MODE_CLEAR] = (state_nxt != odm_pkg::ST_IDLE);
        if (state_nxt != odm_pkg::ST_IDLE) begin
            mode_nxt[odm_pkg::MODE_AUTO_INC] = 1'b0;
        end
    end

    always_comb begin
        high_nxt = high_r;
        if (high_wr && !clearing) begin
            high_nxt = reg_wdata_i[1:0];
        end
    end

    always_comb begin
        ptr_nxt = ptr_r;
        if (auto_enable) begin
            ptr_nxt = host_addr;
        end else if (store && auto_on) begin
            ptr_nxt = ptr_r + 9'h001;
        end
    end

    // ------------------------------------------------------------------
    // State and control registers
    // ------------------------------------------------------------------
    // clear at reset
    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            state_r <= odm_pkg::ST_CLEAR;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            mode_r <= odm_pkg::MODE_RESET;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            high_r <= odm_pkg::HIGH_RESET;
        end else begin
            high_r <= high_nxt;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            ptr_r <= 9'h000;
        end else begin
            ptr_r <= ptr_nxt;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            clr_cnt_r <= 10'h000;
        end else begin
            clr_cnt_r <= clr_cnt_nxt;
        end
    end

    // Previous sync level, resting at the idle level of the pin.
    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            vsync_d_r <= 1'b0;
        end else begin
            vsync_d_r <= vsync_i;
        end
    end

    // ------------------------------------------------------------------
    // Memory write port
    // ------------------------------------------------------------------
    wire in_clear = (state_r == odm_pkg::ST_CLEAR);
    wire clr_write = in_clear && (clr_cnt_r < 10'(odm_pkg::MEM_DEPTH));
    wire glyph_we_nxt = clr_write || (store && !to_attr);
    wire attr_we_nxt = clr_write || (store && (to_attr || !eight_bit));
    wire [8:0] addr_nxt = clr_write ? clr_cnt_r[8:0]
                        : (auto_on ? ptr_r : host_addr);
    wire [7:0] glyph_nxt = clr_write ? 8'h00 : display_data_in_i;
    wire [7:0] attr_nxt = clr_write ? 8'h00
                        : (eight_bit ? display_data_in_i : auto_attr);
    wire [7:0] rdata_nxt = mode_rd ? mode_r
                         : (high_rd ? {6'h00, high_r} : 8'h00);
    wire show_nxt = external_sync_i && !background_mode_i
                    && !char_local_background_i;

    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            glyph_we_r <= 1'b0;
        end else begin
            glyph_we_r <= glyph_we_nxt;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            attr_we_r <= 1'b0;
        end else begin
            attr_we_r <= attr_we_nxt;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            addr_r <= 9'h000;
        end else begin
            addr_r <= addr_nxt;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            glyph_r <= 8'h00;
        end else begin
            glyph_r <= glyph_nxt;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            attr_r <= 8'h00;
        end else begin
            attr_r <= attr_nxt;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            reg_rdata_r <= 8'h00;
        end else begin
            reg_rdata_r <= rdata_nxt;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            show_video_r <= 1'b0;
        end else begin
            show_video_r <= show_nxt;
        end
    end

    // busy at reset
    // Busy falls on the same edge that launches the last zero write.
    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            busy_r <= 1'b1;
        end else begin
            busy_r <= (state_nxt != odm_pkg::ST_IDLE);
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign reg_rdata_o = reg_rdata_r;
    assign mem_glyph_we_o = glyph_we_r;
    assign mem_attr_we_o = attr_we_r;
    assign mem_addr_o = addr_r;
    assign mem_glyph_o = glyph_r;
    assign mem_attr_o = attr_r;
    assign clear_busy_o = busy_r;
    assign show_video_o = show_video_r;

endmodule // odm_ctrl

// ### hdl/odm_pkg.sv
// Package of constants for the display memory access control block.
package odm_pkg;
    // ------------------------------------------------------------------
    // Register addresses (write and read forms)
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_MODE_WR = 8'h04;
    localparam logic [7:0] ADDR_MODE_RD = 8'h84;
    localparam logic [7:0] ADDR_HIGH_WR = 8'h05;
    localparam logic [7:0] ADDR_HIGH_RD = 8'h85;
    // ------------------------------------------------------------------
    // Field positions of display_memory_mode
    // ------------------------------------------------------------------
    localparam int MODE_AUTO_INC = 0;
    localparam int MODE_VS_CLEAR = 1;
    localparam int MODE_CLEAR = 2;
    localparam int MODE_INV = 3;
    localparam int MODE_BLINK = 4;
    localparam int MODE_LBC = 5;
    localparam int MODE_EIGHT_BIT = 6;
    // ------------------------------------------------------------------
    // Field positions of display_address_high
    // ------------------------------------------------------------------
    localparam int HIGH_MSB = 0;
    localparam int HIGH_BYTE_SEL = 1;
    // ------------------------------------------------------------------
    // Reset values and special codes
    // ------------------------------------------------------------------
    localparam logic [7:0] MODE_RESET = 8'h04;
    localparam logic [1:0] HIGH_RESET = 2'h0;
    localparam logic [7:0] ESCAPE_CODE = 8'hFF;
    // ------------------------------------------------------------------
    // Timing of the clear operation
    // ------------------------------------------------------------------
    localparam int CLOCK_PERIOD_NS = 50;
    localparam int CLEAR_TIME_NS = 20000;
    localparam int CLEAR_CYCLES = CLEAR_TIME_NS / CLOCK_PERIOD_NS;
    localparam int ADDR_W = 9;
    localparam int MEM_DEPTH = 1 << ADDR_W;
    // ------------------------------------------------------------------
    // Clear sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT_VS = 3'b010,
        ST_CLEAR = 3'b100
    } odm_state_t;
endpackage
